// [verilog/intc_pkg.sv]
// Shared constants of the interrupt flag, enable and priority block
package intc_pkg;
    localparam int NUM_SRC = 32;
    localparam int NUM_PRIO_REGS = 8;
    localparam int SLOTS_PER_REG = 4;
    localparam int SLOT_STRIDE = 8;
    localparam int PRIO_OFS = 2;
    localparam int SUB_OFS = 0;
    localparam int PRIO_W = 3;
    localparam int SUB_W = 2;
    localparam int KEY_W = PRIO_W + SUB_W;
    localparam int SRC_W = 5;
    localparam int INDEX_W = 6;

    // Word indices on the bus; byte address is four times the index
    localparam logic [5:0] IDX_RELOAD = 6'h00;
    localparam logic [5:0] IDX_FLAGS = 6'h01;
    localparam logic [5:0] IDX_ENABLES = 6'h02;
    localparam logic [5:0] IDX_STATUS = 6'h03;
    localparam logic [5:0] IDX_PRIO_BASE = 6'h04;
    localparam logic [5:0] IDX_PRIO_LAST = 6'h0B;

    // Status word layout
    localparam int STATUS_SRC_LSB = 0;
    localparam int STATUS_PRIO_LSB = 8;

    // Only priority and subpriority bits exist in a priority word
    localparam logic [31:0] PRIO_MASK = 32'h1F1F_1F1F;

    localparam logic [31:0] RST_RELOAD = 32'h0000_0000;
    localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
    localparam logic [31:0] RST_ENABLES = 32'h0000_0000;
    localparam logic [31:0] RST_PRIO = 32'h0000_0000;
    localparam logic [7:0] RST_LAST = 8'h00;
    localparam logic [31:0] RST_TIMER = 32'h0000_0000;
endpackage

// [verilog/source_rank.sv]
// Eligibility and ordering key of one interrupt source
module source_rank
    import intc_pkg::*;
(
    input wire logic flag,
    input wire logic enable,
    input wire logic [intc_pkg::PRIO_W-1:0] level,
    input wire logic [intc_pkg::SUB_W-1:0] subpriority,
    output logic eligible,
    output logic [intc_pkg::KEY_W-1:0] key
);
    always_comb
    begin
        // Priority code zero disables the source even when enabled
        eligible = flag & enable & (level != '0);
        // Subpriority sits below priority so it only breaks ties
        key = {level, subpriority};
    end
endmodule

// [verilog/proximity_loader.sv]
// Proximity timer register, reloaded by an interrupt event
module proximity_loader
    import intc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic trigger,
    input wire logic [31:0] reloadValue,
    output logic [31:0] timerValue
);
    typedef struct packed {
        logic [31:0] count;
    } prox_state_t;

    prox_state_t st_q;
    prox_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (trigger)
        begin
            st_d.count = reloadValue;
        end
        else if (st_q.count != '0)
        begin
            st_d.count = st_q.count - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_q.count <= RST_TIMER;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign timerValue = st_q.count;

    timer_reload_a: assert property (@(posedge clk) disable iff (!nrst)
        trigger |=> timerValue == $past(reloadValue))
        else $error("proximity timer did not take the reload value");
endmodule

// [verilog/intc_core.sv]
// Interrupt flag, enable and priority registers with an AHB-Lite slave
//
// Our own choices: register access over AHB-Lite and the address map.
module intc_core
    import intc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [intc_pkg::NUM_SRC-1:0] srcRequest,
    input wire logic cpuAck,
    output logic irqValid,
    output logic [intc_pkg::SRC_W-1:0] irqSource,
    output logic [intc_pkg::PRIO_W-1:0] irqPriority,
    output logic [31:0] proxTimerValue
);
    import intc_pkg::*;

    typedef struct packed {
        logic [31:0] reload;
        logic [31:0] flags;
        logic [31:0] enables;
        logic [NUM_PRIO_REGS-1:0][31:0] prio;
        logic [7:0] lastServiced;
        logic irqValid;
        logic [SRC_W-1:0] irqSource;
        logic [PRIO_W-1:0] irqPriority;
        logic dataPhase;
        logic dataWrite;
        logic [INDEX_W-1:0] dataIndex;
        logic [31:0] rdata;
        logic readyOut;
    } core_state_t;

    core_state_t st_q;
    core_state_t st_d;

    logic [NUM_SRC-1:0] eligible;
    logic [NUM_SRC-1:0][KEY_W-1:0] rankKey;
    logic proxTrigger;

    ////////////////////////////////////////////////////////////////////////
    // Per-source ranking

    // Source i lives in flag and enable bit i and in slot i%4 of
    // priority word i/4, so every array agrees on the source number
    for (genvar i = 0; i < NUM_SRC; i++)
    begin : gen_rank
        localparam int REG = i / SLOTS_PER_REG;
        localparam int SLOT = i % SLOTS_PER_REG;
        localparam int PLSB = SLOT * SLOT_STRIDE + PRIO_OFS;
        localparam int SLSB = SLOT * SLOT_STRIDE + SUB_OFS;

        source_rank u_rank (
            .flag(st_q.flags[i]),
            .enable(st_q.enables[i]),
            .level(st_q.prio[REG][PLSB +: PRIO_W]),
            .subpriority(st_q.prio[REG][SLSB +: SUB_W]),
            .eligible(eligible[i]),
            .key(rankKey[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Proximity timer

    // Any enabled request counts as an interrupt event
    assign proxTrigger = |(srcRequest & st_q.enables);

    proximity_loader u_prox (
        .clk(clk),
        .nrst(nrst),
        .trigger(proxTrigger),
        .reloadValue(st_q.reload),
        .timerValue(proxTimerValue)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic bestFound;
        logic [KEY_W-1:0] bestKey;
        logic [SRC_W-1:0] bestSrc;
        logic [INDEX_W-1:0] prioIdx;
        logic [INDEX_W-1:0] addrIdx;
        logic [INDEX_W-1:0] rdPrioIdx;
        bestFound = 1'b0;
        bestKey = '0;
        bestSrc = '0;
        prioIdx = '0;
        addrIdx = '0;
        rdPrioIdx = '0;
        st_d = st_q;
        st_d.readyOut = 1'b1;

        // Data phase of a write; unmapped words are dropped silently
        if (st_q.dataPhase && st_q.dataWrite)
        begin
            case (st_q.dataIndex)
                IDX_RELOAD:
                begin
                    st_d.reload = hwdata;
                end
                IDX_FLAGS:
                begin
                    st_d.flags = hwdata;
                end
                IDX_ENABLES:
                begin
                    st_d.enables = hwdata;
                end
                default:
                begin
                    if (st_q.dataIndex >= IDX_PRIO_BASE &&
                        st_q.dataIndex <= IDX_PRIO_LAST)
                    begin
                        prioIdx = st_q.dataIndex - IDX_PRIO_BASE;
                        // Unimplemented bits never store anything
                        st_d.prio[prioIdx[2:0]] = hwdata & PRIO_MASK;
                    end
                end
            endcase
        end

        // A request in the same cycle as a clearing write still lands
        st_d.flags = st_d.flags | srcRequest;

        // Winner search; strict compare keeps the lowest index on ties
        for (int s = 0; s < NUM_SRC; s++)
        begin
            if (eligible[s] && (!bestFound || rankKey[s] > bestKey))
            begin
                bestFound = 1'b1;
                bestKey = rankKey[s];
                bestSrc = SRC_W'(s);
            end
        end

        // The CPU takes the source it is shown in the same cycle as its ack
        if (cpuAck && st_q.irqValid)
        begin
            st_d.lastServiced = 8'(st_q.irqSource);
        end

        st_d.irqValid = bestFound;
        st_d.irqSource = bestSrc;
        st_d.irqPriority = bestKey[KEY_W-1 -: PRIO_W];

        // Address phase; read data is built from the next state so a
        // read straight after a write returns the new value
        st_d.dataPhase = 1'b0;
        st_d.dataWrite = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            addrIdx = haddr[INDEX_W+1:2];
            if (haddr[31:INDEX_W+2] != '0)
            begin
                addrIdx = '1;
            end
            st_d.dataPhase = 1'b1;
            st_d.dataWrite = hwrite;
            st_d.dataIndex = addrIdx;
            st_d.rdata = 32'h0000_0000;
            if (!hwrite)
            begin
                case (addrIdx)
                    IDX_RELOAD:
                    begin
                        st_d.rdata = st_d.reload;
                    end
                    IDX_FLAGS:
                    begin
                        st_d.rdata = st_d.flags;
                    end
                    IDX_ENABLES:
                    begin
                        st_d.rdata = st_d.enables;
                    end
                    IDX_STATUS:
                    begin
                        st_d.rdata[STATUS_SRC_LSB +: 8] = st_d.lastServiced;
                        st_d.rdata[STATUS_PRIO_LSB +: PRIO_W] =
                            st_q.irqPriority;
                    end
                    default:
                    begin
                        if (addrIdx >= IDX_PRIO_BASE &&
                            addrIdx <= IDX_PRIO_LAST)
                        begin
                            rdPrioIdx = addrIdx - IDX_PRIO_BASE;
                            st_d.rdata = st_d.prio[rdPrioIdx[2:0]];
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_q.reload <= RST_RELOAD;
            st_q.flags <= RST_FLAGS;
            st_q.enables <= RST_ENABLES;
            st_q.prio <= {NUM_PRIO_REGS{RST_PRIO}};
            st_q.lastServiced <= RST_LAST;
            st_q.irqValid <= 1'b0;
            st_q.irqSource <= '0;
            st_q.irqPriority <= '0;
            st_q.dataPhase <= 1'b0;
            st_q.dataWrite <= 1'b0;
            st_q.dataIndex <= '0;
            st_q.rdata <= 32'h0000_0000;
            st_q.readyOut <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign hrdata = st_q.rdata;
    assign hreadyout = st_q.readyOut;
    // Every transfer completes with OKAY, mapped or not
    assign hresp = 1'b0;
    assign irqValid = st_q.irqValid;
    assign irqSource = st_q.irqSource;
    assign irqPriority = st_q.irqPriority;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
        (|srcRequest) |=> ((st_q.flags & $past(srcRequest)) ==
            $past(srcRequest)))
        else $error("request did not set its flag");

    flag_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_q.dataPhase && st_q.dataWrite && st_q.dataIndex == IDX_FLAGS &&
            srcRequest == '0) |=> st_q.flags == $past(hwdata))
        else $error("flag write not stored");

    enable_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_q.dataPhase && st_q.dataWrite &&
            st_q.dataIndex == IDX_ENABLES) |=> st_q.enables == $past(hwdata))
        else $error("enable write not stored");

    prio_unimpl_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_q.prio[0] & ~PRIO_MASK) == '0 &&
        (st_q.prio[NUM_PRIO_REGS-1] & ~PRIO_MASK) == '0)
        else $error("unimplemented priority bit holds a one");

    prio_nonzero_a: assert property (@(posedge clk) disable iff (!nrst)
        irqValid |-> irqPriority != '0)
        else $error("source with priority zero was presented");

    present_any_a: assert property (@(posedge clk) disable iff (!nrst)
        (|eligible) |=> irqValid)
        else $error("eligible source was not presented");

    present_none_a: assert property (@(posedge clk) disable iff (!nrst)
        !(|eligible) |=> !irqValid)
        else $error("request presented with nothing eligible");

    winner_key_a: assert property (@(posedge clk) disable iff (!nrst)
        irqValid |-> irqPriority ==
            $past(rankKey[st_d.irqSource][KEY_W-1 -: PRIO_W]))
        else $error("presented priority differs from the winner");

    presented_ok_a: assert property (@(posedge clk) disable iff (!nrst)
        irqValid |-> $past(eligible[st_d.irqSource]))
        else $error("presented source was not eligible");

    flag_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (!(st_q.dataPhase && st_q.dataWrite &&
            st_q.dataIndex == IDX_FLAGS) && srcRequest == '0) |=>
            $stable(st_q.flags))
        else $error("flags changed without a write or a request");

    reload_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_q.dataPhase && st_q.dataWrite &&
            st_q.dataIndex == IDX_RELOAD) |=> st_q.reload == $past(hwdata))
        else $error("reload write not stored");

    prio_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_q.dataPhase && st_q.dataWrite &&
            st_q.dataIndex == IDX_PRIO_BASE) |=>
            st_q.prio[0] == ($past(hwdata) & PRIO_MASK))
        else $error("priority write not stored through the mask");

    status_read_a: assert property (@(posedge clk) disable iff (!nrst)
        (hsel && htrans[1] && hready && !hwrite && haddr[31:INDEX_W+2] == '0
            && haddr[INDEX_W+1:2] == IDX_STATUS) |=>
            hrdata[STATUS_SRC_LSB +: 8] == st_q.lastServiced)
        else $error("status read lost the serviced source number");

    last_served_a: assert property (@(posedge clk) disable iff (!nrst)
        (cpuAck && irqValid) |=> st_q.lastServiced ==
            8'($past(irqSource)))
        else $error("serviced source number not recorded");

    ready_high_a: assert property (@(posedge clk) disable iff (!nrst)
        hreadyout && !hresp)
        else $error("slave inserted a wait state or an error");
endmodule

// [tb/cpu_model.sv]
// Processor core model that takes presented interrupts
module cpu_model
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ackOn,
    input wire logic irqValid,
    output logic cpuAck
);
    timeunit 1ns;
    timeprecision 1ps;

    // One idle cycle between acks keeps a slow core from double counting
    always_ff @(posedge clk)
    begin
        if (!nrst)
            cpuAck <= 1'b0;
        else
            cpuAck <= ackOn && irqValid && !cpuAck;
    end
endmodule

// [tb/tb.sv]
// Self-checking bench of the interrupt flag, enable and priority block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import intc_pkg::*;

    logic clk, nrst, hwrite, hready, hreadyout, hresp, cpuAck, ackOn;
    logic irqValid;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, proxTimerValue, srcRequest;
    logic [4:0] irqSource;
    logic [2:0] irqPriority;
    int num_errors = 0;
    int total_checks = 0;

    assign hready = hreadyout;

    intc_core uut (.clk(clk), .nrst(nrst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .srcRequest(srcRequest), .cpuAck(cpuAck),
        .irqValid(irqValid), .irqSource(irqSource),
        .irqPriority(irqPriority), .proxTimerValue(proxTimerValue));

    cpu_model core (.clk(clk), .nrst(nrst), .ackOn(ackOn),
        .irqValid(irqValid), .cpuAck(cpuAck));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic waitReady();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                $display("Error at %0t: bus wait timed out", $time);
                num_errors++;
                summarize();
            end
            @(posedge clk);
        end
    endtask

    // Entered just after a rising edge; read data taken at the last edge
    task automatic busXfer(input logic [31:0] addr, input logic wr,
        input logic [31:0] wdata, output logic [31:0] rdata);
        haddr <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        waitReady();
        htrans <= 2'b00;
        hwdata <= wdata;
        waitReady();
        rdata = hrdata;
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask

    function automatic logic [31:0] adr(input logic [5:0] i);
        return {24'h00_0000, i, 2'b00};
    endfunction

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        busXfer(addr, 1'b1, data, dummy);
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        busXfer(addr, 1'b0, 32'h0000_0000, got);
        chk(got, exp);
    endtask

    // Presentation launches one edge after the committing write; it is
    // looked at on the edge after that, while it stands
    task automatic irqChk(input logic v, input logic [4:0] s,
        input logic [2:0] p);
        repeat (2) @(posedge clk);
        chk({31'h0000_0000, irqValid}, {31'h0000_0000, v});
        if (v)
            chk({24'h00_0000, irqSource, irqPriority}, {24'h00_0000, s, p});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        for (int i = 0; i < 12; i++)
            rd(adr(6'(i)), 32'h0000_0000);
        wr(32'h0000_0100, 32'hFFFF_FFFF);
        rd(32'h0000_0100, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic testFlags();
        srcRequest <= 32'h0000_0200;
        @(posedge clk);
        srcRequest <= 32'h0000_0000;
        rd(adr(IDX_FLAGS), 32'h0000_0200);
        wr(adr(IDX_FLAGS), 32'hA5A5_0F0F);
        rd(adr(IDX_FLAGS), 32'hA5A5_0F0F);
        wr(adr(IDX_FLAGS), 32'h0000_0000);
        rd(adr(IDX_FLAGS), 32'h0000_0000);
        wr(adr(IDX_ENABLES), 32'h5A5A_F0F0);
        rd(adr(IDX_ENABLES), 32'h5A5A_F0F0);
        $display("test flags done");
    endtask

    task automatic testMask();
        for (int k = 0; k < 8; k++)
        begin
            wr(adr(IDX_PRIO_BASE + 6'(k)), 32'hFFFF_FFFF);
            rd(adr(IDX_PRIO_BASE + 6'(k)), 32'h1F1F_1F1F);
            wr(adr(IDX_PRIO_BASE + 6'(k)), 32'h0000_0000);
        end
        $display("test mask done");
    endtask

    task automatic testSlots();
        wr(adr(IDX_ENABLES), 32'hFFFF_FFFF);
        wr(adr(IDX_FLAGS), 32'h0000_000F);
        for (int s = 0; s < 4; s++)
        begin
            wr(adr(IDX_PRIO_BASE), 32'h0000_001C << (8 * s));
            irqChk(1'b1, 5'(s), 3'h7);
        end
        wr(adr(IDX_PRIO_BASE), 32'h0000_0000);
        $display("test slots done");
    endtask

    task automatic testArb();
        // Sources 4 to 7: prio 3 sub 1, prio 3 sub 2, off sub 3, prio 3 sub 2
        wr(adr(IDX_PRIO_BASE + 6'h01), 32'h0E03_0E0D);
        wr(adr(IDX_FLAGS), 32'h0000_00F0);
        irqChk(1'b1, 5'h05, 3'h3);
        wr(adr(IDX_FLAGS), 32'h0000_0040);
        irqChk(1'b0, 5'h00, 3'h0);
        wr(adr(IDX_FLAGS), 32'h0000_0010);
        wr(adr(IDX_ENABLES), 32'hFFFF_FFEF);
        irqChk(1'b0, 5'h00, 3'h0);
        wr(adr(IDX_ENABLES), 32'hFFFF_FFFF);
        $display("test arbitration done");
    endtask

    task automatic testAck();
        wr(adr(IDX_FLAGS), 32'h0000_0020);
        irqChk(1'b1, 5'h05, 3'h3);
        ackOn <= 1'b1;
        repeat (3) @(posedge clk);
        ackOn <= 1'b0;
        rd(adr(IDX_STATUS), 32'h0000_0305);
        $display("test ack done");
    endtask

    task automatic testTimer();
        wr(adr(IDX_RELOAD), 32'h8765_4321);
        rd(adr(IDX_RELOAD), 32'h8765_4321);
        wr(adr(IDX_ENABLES), 32'h0000_0004);
        srcRequest <= 32'h0000_0004;
        @(posedge clk);
        srcRequest <= 32'h0000_0000;
        @(posedge clk);
        chk(proxTimerValue, 32'h8765_4321);
        @(posedge clk);
        chk(proxTimerValue, 32'h8765_4320);
        $display("test timer done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        srcRequest = 32'h0000_0000;
        ackOn = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        testReset();
        testFlags();
        testMask();
        testSlots();
        testArb();
        testAck();
        testTimer();
        summarize();
    end
endmodule
